/* File: core/nvc_pkg.sv */
// Constants shared by the nonvolatile SRAM store/recall host controller.
package nvc_pkg;
    localparam int ADDR_W = 13;
    localparam int DATA_W = 8;
    localparam int CLK_PERIOD_NS = 100;
    // Nonvolatile and pin timing, in nanoseconds as the device is specified.
    localparam int T_STORE_NS = 10000000;
    localparam int T_RECALL_NS = 20000;
    localparam int T_HSB_ASSERT_NS = 250;
    localparam int T_HSB_INHIBIT_NS = 1000;
    // Waits are least times for the host, so every count rounds up.
    localparam int STORE_CYCLES = (T_STORE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RECALL_CYCLES = (T_RECALL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HSB_ASSERT_CYCLES = (T_HSB_ASSERT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HSB_INHIBIT_CYCLES = (T_HSB_INHIBIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Six-read unlock sequence; the last entry picks store or recall.
    localparam logic [12:0] SEQ_ADDR_0 = 13'h0000;
    localparam logic [12:0] SEQ_ADDR_1 = 13'h1555;
    localparam logic [12:0] SEQ_ADDR_2 = 13'h0AAA;
    localparam logic [12:0] SEQ_ADDR_3 = 13'h1FFF;
    localparam logic [12:0] SEQ_ADDR_4 = 13'h10F0;
    localparam logic [12:0] SEQ_ADDR_STORE = 13'h0F0F;
    localparam logic [12:0] SEQ_ADDR_RECALL = 13'h0F0E;
    localparam logic [2:0] SEQ_LAST_STEP = 3'h5;
    typedef enum logic [2:0] {
        NVC_OP_READ = 3'h0,
        NVC_OP_WRITE = 3'h1,
        NVC_OP_SW_STORE = 3'h2,
        NVC_OP_SW_RECALL = 3'h3,
        NVC_OP_HW_STORE = 3'h4
    } nvc_op_type;
endpackage

/* File: core/nvc_timer_if.sv */
// Load and done handshake between the controller and its wait timer.
`timescale 1ns/1ns
interface nvc_timer_if #(
    parameter int TIMER_W = 17
);
    logic load;
    logic [TIMER_W-1:0] count;
    logic done;
    modport ctrl (output load, output count, input done);
    modport tmr (input load, input count, output done);
endinterface

/* File: core/nvc_wait_timer.sv */
// Down counter that times nonvolatile cycles and pin pulses.
`timescale 1ns/1ns
module nvc_wait_timer #(
    parameter int TIMER_W = 17,
    parameter logic [TIMER_W-1:0] INIT_COUNT = '0
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    nvc_timer_if.tmr tmr_bus
);
    logic [TIMER_W-1:0] cnt_reg;
    logic [TIMER_W-1:0] cnt_next;

    // A counter without bits cannot time anything.
    if (TIMER_W < 1)
    begin : g_bad_width
        $error("nvc_wait_timer: timer width must be at least one bit");
    end

    // A load wins over the running count; the counter rests at zero.
    always_comb
    begin
        cnt_next = cnt_reg;
        if (tmr_bus.load)
            cnt_next = tmr_bus.count;
        else if (cnt_reg != '0)
            cnt_next = cnt_reg - 1'b1;
    end

    // The reset value lets the power-up recall wait start without a load.
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            cnt_reg <= INIT_COUNT;
        else
            cnt_reg <= cnt_next;
    end

    assign tmr_bus.done = (cnt_reg == '0);
endmodule // nvc_wait_timer

/* File: core/nvc_host_ctrl.sv */
// Host controller driving an 8K x 8 nonvolatile SRAM through its pins.
`timescale 1ns/1ns
module nvc_host_ctrl
    import nvc_pkg::*;
#(
    parameter int TIMER_W = 17,
    parameter int STORE_WAIT = nvc_pkg::STORE_CYCLES,
    parameter int RECALL_WAIT = nvc_pkg::RECALL_CYCLES
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic cmd_valid_in,
    input wire nvc_pkg::nvc_op_type cmd_op_in,
    input wire logic [nvc_pkg::ADDR_W-1:0] cmd_addr_in,
    input wire logic [nvc_pkg::DATA_W-1:0] cmd_wdata_in,
    output logic cmd_ready_out,
    output logic rsp_valid_out,
    output logic [nvc_pkg::DATA_W-1:0] rsp_rdata_out,
    output logic chip_sel_n_out,
    output logic write_n_out,
    output logic out_en_n_out,
    output logic [nvc_pkg::ADDR_W-1:0] address_bus_out,
    input wire logic [nvc_pkg::DATA_W-1:0] data_bus_in,
    output logic [nvc_pkg::DATA_W-1:0] data_bus_out,
    output logic data_bus_oe_out,
    input wire logic store_busy_pin_n_in,
    output logic store_busy_pin_n_out,
    output logic store_busy_pin_n_oe_out
);
    import nvc_pkg::*;

    typedef enum logic [3:0] {
        ST_POWERUP = 4'h0,
        ST_IDLE = 4'h1,
        ST_SETUP = 4'h3,
        ST_STROBE = 4'h2,
        ST_HOLD = 4'h6,
        ST_RELEASE = 4'h7,
        ST_NV_WAIT = 4'h5,
        ST_HSB_DRIVE = 4'h4,
        ST_HSB_SETTLE = 4'hC,
        ST_HSB_WAIT = 4'hD
    } nvc_state_type;

    // Refuse timer widths that cannot hold the longest wait.
    if (STORE_WAIT < 1 || RECALL_WAIT < 1 || STORE_WAIT >= 2 ** TIMER_W
        || RECALL_WAIT >= 2 ** TIMER_W)
    begin : g_bad_timer
        $error("nvc_host_ctrl: wait counts do not fit the timer");
    end

    nvc_state_type state_reg, state_next;
    nvc_op_type op_reg, op_next;
    logic [2:0] step_reg, step_next;
    logic [ADDR_W-1:0] addr_reg, addr_next;
    logic [DATA_W-1:0] dq_reg, dq_next;
    logic dq_oe_reg, dq_oe_next;
    logic ce_n_reg, ce_n_next;
    logic we_n_reg, we_n_next;
    logic oe_n_reg, oe_n_next;
    logic hsb_oe_reg, hsb_oe_next;
    logic ready_reg, ready_next;
    logic rsp_reg, rsp_next;
    logic [DATA_W-1:0] rdata_reg, rdata_next;
    logic seq_op;

    nvc_timer_if #(.TIMER_W(TIMER_W)) tmr_bus ();

    // The timer starts loaded so the power-up recall is waited out.
    nvc_wait_timer #(
        .TIMER_W(TIMER_W),
        .INIT_COUNT(TIMER_W'(RECALL_WAIT))
    ) u_timer (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .tmr_bus(tmr_bus)
    );

    // Address of a given step of the unlock read sequence.
    function automatic logic [ADDR_W-1:0] seq_addr(input logic [2:0] step,
                                                   input logic recall);
        unique case (step)
            3'h0: seq_addr = SEQ_ADDR_0;
            3'h1: seq_addr = SEQ_ADDR_1;
            3'h2: seq_addr = SEQ_ADDR_2;
            3'h3: seq_addr = SEQ_ADDR_3;
            3'h4: seq_addr = SEQ_ADDR_4;
            default: seq_addr = recall ? SEQ_ADDR_RECALL : SEQ_ADDR_STORE;
        endcase
    endfunction

    assign seq_op = (op_reg == NVC_OP_SW_STORE) || (op_reg == NVC_OP_SW_RECALL);

    // Pin sequencing. Every access is setup, two strobe cycles and a release,
    // so chip select always toggles between steps and clocks in each address.
    always_comb
    begin
        state_next = state_reg;
        op_next = op_reg;
        step_next = step_reg;
        addr_next = addr_reg;
        dq_next = dq_reg;
        dq_oe_next = dq_oe_reg;
        ce_n_next = ce_n_reg;
        we_n_next = we_n_reg;
        oe_n_next = oe_n_reg;
        hsb_oe_next = hsb_oe_reg;
        rsp_next = 1'b0;
        rdata_next = rdata_reg;
        tmr_bus.load = 1'b0;
        tmr_bus.count = '0;
        unique case (state_reg)
            ST_POWERUP:
            begin
                // Hold off until the automatic recall and any busy pin are done.
                if (tmr_bus.done && store_busy_pin_n_in)
                    state_next = ST_IDLE;
            end
            ST_IDLE:
            begin
                if (cmd_valid_in && ready_reg)
                begin
                    op_next = cmd_op_in;
                    step_next = 3'h0;
                    state_next = ST_SETUP;
                    unique case (cmd_op_in)
                        NVC_OP_READ: addr_next = cmd_addr_in;
                        NVC_OP_WRITE:
                        begin
                            // Write strobe falls before chip select, so the
                            // device never drives the bus against us.
                            addr_next = cmd_addr_in;
                            dq_next = cmd_wdata_in;
                            dq_oe_next = 1'b1;
                            we_n_next = 1'b0;
                        end
                        NVC_OP_SW_STORE: addr_next = seq_addr(3'h0, 1'b0);
                        NVC_OP_SW_RECALL: addr_next = seq_addr(3'h0, 1'b1);
                        NVC_OP_HW_STORE:
                        begin
                            hsb_oe_next = 1'b1;
                            tmr_bus.load = 1'b1;
                            tmr_bus.count = TIMER_W'(HSB_ASSERT_CYCLES);
                            state_next = ST_HSB_DRIVE;
                        end
                        default:
                        begin
                            // Unknown operations are answered at once, untouched.
                            rsp_next = 1'b1;
                            state_next = ST_IDLE;
                        end
                    endcase
                end
            end
            ST_SETUP:
            begin
                ce_n_next = 1'b0;
                oe_n_next = (op_reg == NVC_OP_WRITE);
                state_next = ST_STROBE;
            end
            ST_STROBE: state_next = ST_HOLD;
            ST_HOLD:
            begin
                ce_n_next = 1'b1;
                oe_n_next = 1'b1;
                if (op_reg == NVC_OP_READ)
                    rdata_next = data_bus_in;
                rsp_next = !seq_op;
                state_next = ST_RELEASE;
            end
            ST_RELEASE:
            begin
                we_n_next = 1'b1;
                dq_oe_next = 1'b0;
                state_next = ST_IDLE;
                if (seq_op && step_reg != SEQ_LAST_STEP)
                begin
                    // Next step follows with no other access in between.
                    step_next = step_reg + 3'h1;
                    addr_next = seq_addr(step_reg + 3'h1, op_reg == NVC_OP_SW_RECALL);
                    state_next = ST_SETUP;
                end
                else if (seq_op)
                begin
                    // The sixth read started the cycle; stay off the bus.
                    tmr_bus.load = 1'b1;
                    tmr_bus.count = (op_reg == NVC_OP_SW_RECALL) ?
                        TIMER_W'(RECALL_WAIT) : TIMER_W'(STORE_WAIT);
                    state_next = ST_NV_WAIT;
                end
            end
            ST_NV_WAIT:
            begin
                if (tmr_bus.done)
                begin
                    rsp_next = 1'b1;
                    state_next = ST_IDLE;
                end
            end
            ST_HSB_DRIVE:
            begin
                if (tmr_bus.done)
                begin
                    hsb_oe_next = 1'b0;
                    tmr_bus.load = 1'b1;
                    tmr_bus.count = TIMER_W'(HSB_INHIBIT_CYCLES);
                    state_next = ST_HSB_SETTLE;
                end
            end
            ST_HSB_SETTLE:
            begin
                // Give the device time to take the pin low itself.
                if (tmr_bus.done)
                    state_next = ST_HSB_WAIT;
            end
            ST_HSB_WAIT:
            begin
                // The device holds the pin low while it stores or inhibits.
                if (store_busy_pin_n_in)
                begin
                    rsp_next = 1'b1;
                    state_next = ST_IDLE;
                end
            end
            default: state_next = ST_POWERUP;
        endcase
        // Another party holding the pin low also keeps us off the bus.
        ready_next = (state_next == ST_IDLE) && store_busy_pin_n_in;
    end

    // Registers behind every pin so the device sees glitch-free edges.
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            state_reg <= ST_POWERUP;
            op_reg <= NVC_OP_READ;
            step_reg <= 3'h0;
            addr_reg <= '0;
            dq_reg <= '0;
            dq_oe_reg <= 1'b0;
            ce_n_reg <= 1'b1;
            we_n_reg <= 1'b1;
            oe_n_reg <= 1'b1;
            hsb_oe_reg <= 1'b0;
            ready_reg <= 1'b0;
            rsp_reg <= 1'b0;
            rdata_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
            op_reg <= op_next;
            step_reg <= step_next;
            addr_reg <= addr_next;
            dq_reg <= dq_next;
            dq_oe_reg <= dq_oe_next;
            ce_n_reg <= ce_n_next;
            we_n_reg <= we_n_next;
            oe_n_reg <= oe_n_next;
            hsb_oe_reg <= hsb_oe_next;
            ready_reg <= ready_next;
            rsp_reg <= rsp_next;
            rdata_reg <= rdata_next;
        end
    end

    // Outputs straight from flip-flops or tied low; the pin only ever pulls low.
    assign cmd_ready_out = ready_reg;
    assign rsp_valid_out = rsp_reg;
    assign rsp_rdata_out = rdata_reg;
    assign chip_sel_n_out = ce_n_reg;
    assign write_n_out = we_n_reg;
    assign out_en_n_out = oe_n_reg;
    assign address_bus_out = addr_reg;
    assign data_bus_out = dq_reg;
    assign data_bus_oe_out = dq_oe_reg;
    assign store_busy_pin_n_out = 1'b0;
    assign store_busy_pin_n_oe_out = hsb_oe_reg;

    sequence strobe_s;
        state_reg == ST_STROBE ##1 state_reg == ST_HOLD ##1 state_reg == ST_RELEASE;
    endsequence

    seq_read_only_a: assert property (
        @(posedge clk_in) disable iff (!rst_n_in)
        seq_op && !ce_n_reg |-> we_n_reg && !dq_oe_reg)
        else $error("write strobe low during unlock sequence");

    seq_step_addr_a: assert property (
        @(posedge clk_in) disable iff (!rst_n_in)
        seq_op && $fell(ce_n_reg) |-> strobe_s and
        (address_bus_out == seq_addr(step_reg, op_reg == NVC_OP_SW_RECALL))[*3])
        else $error("unlock address wrong or unstable");

    seq_no_gap_a: assert property (
        @(posedge clk_in) disable iff (!rst_n_in)
        seq_op && state_reg == ST_RELEASE && step_reg < SEQ_LAST_STEP
        |=> state_reg == ST_SETUP ##1 $fell(ce_n_reg))
        else $error("gap between unlock steps");

    store_start_a: assert property (
        @(posedge clk_in) disable iff (!rst_n_in)
        $rose(state_reg == ST_NV_WAIT) && op_reg == NVC_OP_SW_STORE
        |-> $past(address_bus_out) == SEQ_ADDR_STORE && $past(step_reg) == 3'h5)
        else $error("store started without full sequence");

    recall_start_a: assert property (
        @(posedge clk_in) disable iff (!rst_n_in)
        $rose(state_reg == ST_NV_WAIT) && op_reg == NVC_OP_SW_RECALL
        |-> $past(address_bus_out) == SEQ_ADDR_RECALL && $past(step_reg) == 3'h5)
        else $error("recall started without full sequence");

    hsb_pulse_a: assert property (
        @(posedge clk_in) disable iff (!rst_n_in)
        $rose(hsb_oe_reg) |-> (hsb_oe_reg && ce_n_reg)[*4] ##1 (!hsb_oe_reg && ce_n_reg))
        else $error("store pin pulse too short or too long");
endmodule // nvc_host_ctrl

/* File: verification/nvc_sram_model.sv */
// Behavioural model of the nonvolatile SRAM that the host controller drives.
`timescale 1ns/1ns
module nvc_sram_model
    import nvc_pkg::*;
#(
    parameter int STORE_NS = 1900,
    parameter int RECALL_NS = 800,
    parameter int PDSTORE_MAX_NS = 12000000
) (
    input wire logic chip_sel_n_in,
    input wire logic write_n_in,
    input wire logic out_en_n_in,
    input wire logic [12:0] address_bus_in,
    input wire logic [7:0] data_bus_in,
    output logic [7:0] data_bus_out,
    output logic data_bus_oe_out,
    input wire logic store_busy_pin_n_in,
    output logic store_busy_pull_out,
    output logic [7:0] store_count_out,
    output logic [7:0] recall_count_out
);
    logic [7:0] mem [0:8191];
    logic [7:0] nv [0:8191];
    logic [12:0] seq_tab [0:4];
    logic [12:0] addr_q;
    logic busy = 1'b1;
    logic written = 1'b0;
    logic hiz = 1'b0;
    int step = 0;

    // The same store task serves a power-loss store, so it must fit that budget.
    if (STORE_NS > PDSTORE_MAX_NS)
    begin : g_slow_store
        $error("nvc_sram_model: store outlasts the power-loss budget");
    end

    // Outputs drive only in a read with the enable low; the step that starts a store or recall floats.
    assign data_bus_oe_out = !chip_sel_n_in && write_n_in && !out_en_n_in && !busy
        && store_busy_pin_n_in && !hiz;
    assign data_bus_out = mem[address_bus_in];

    // A nonvolatile cycle runs to its end whatever the host does meanwhile.
    task automatic do_store();
        busy = 1'b1;
        store_busy_pull_out = 1'b1;
        #STORE_NS;
        foreach (nv[i]) nv[i] = mem[i];
        written = 1'b0;
        store_count_out = store_count_out + 8'h01;
        store_busy_pull_out = 1'b0;
        busy = 1'b0;
    endtask

    task automatic do_recall();
        busy = 1'b1;
        #RECALL_NS;
        foreach (mem[i]) mem[i] = nv[i];
        recall_count_out = recall_count_out + 8'h01;
        busy = 1'b0;
    endtask

    // Power-up fills the array from a fixed nonvolatile pattern.
    initial
    begin
        seq_tab = '{SEQ_ADDR_0, SEQ_ADDR_1, SEQ_ADDR_2, SEQ_ADDR_3, SEQ_ADDR_4};
        store_busy_pull_out = 1'b0;
        store_count_out = 8'h00;
        recall_count_out = 8'h00;
        foreach (nv[i]) nv[i] = i[7:0] ^ 8'hC3;
        do_recall();
    end

    // Address and float decision are taken as the chip is selected.
    always @(negedge chip_sel_n_in)
    begin
        addr_q = address_bus_in;
        if (!busy && store_busy_pin_n_in)
            hiz = !write_n_in || (step == 5 && (address_bus_in == SEQ_ADDR_STORE
                || address_bus_in == SEQ_ADDR_RECALL));
    end

    // The end of each access writes, or advances or aborts the unlock sequence.
    always @(posedge chip_sel_n_in)
    begin
        hiz = 1'b0;
        if (!busy && store_busy_pin_n_in)
        begin
            if (!write_n_in)
            begin
                mem[addr_q] = data_bus_in;
                written = 1'b1;
                step = 0;
            end
            else if (step < 5 && addr_q == seq_tab[step])
                step++;
            else if (step == 5 && addr_q == SEQ_ADDR_STORE)
            begin
                step = 0;
                do_store();
            end
            else if (step == 5 && addr_q == SEQ_ADDR_RECALL)
            begin
                step = 0;
                do_recall();
            end
            else
                step = (addr_q == SEQ_ADDR_0) ? 1 : 0;
        end
    end

    // A pin store is skipped when nothing was written since the last store.
    always @(negedge store_busy_pin_n_in)
        if (!busy && written)
            do_store();
endmodule // nvc_sram_model

/* File: verification/nvsram_store_recall_control_bench.sv */
// Self-checking bench of the host controller against the SRAM model.
`timescale 1ns/1ns
module nvsram_store_recall_control_bench;
    import nvc_pkg::*;
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic cmd_valid_in = 1'b0;
    nvc_op_type cmd_op_in = NVC_OP_READ;
    logic [12:0] cmd_addr_in = 13'h0000;
    logic [7:0] cmd_wdata_in = 8'h00;
    logic cmd_ready, rsp_valid, cs_n, we_n, oe_n, c_oe, d_oe, pin_out, pin_oe, d_pull;
    logic [7:0] rdata, c_data, d_data, stores, recalls;
    logic [12:0] addr;
    logic float_pat = 1'b0;
    wire logic [7:0] data_wire;
    wire logic pin_wire;
    int fail_count = 0;
    int check_count = 0;
    logic [7:0] rd;
    int cs_falls = 0;

    initial
    begin
        forever #50 clk_in = ~clk_in;
    end

    // A released data bus shows a toggling pattern, never the last value.
    always @(posedge clk_in) float_pat <= ~float_pat;
    assign data_wire = c_oe ? c_data : (d_oe ? d_data : {8{float_pat}});
    assign pin_wire = d_pull ? 1'b0 : (pin_oe ? pin_out : 1'b1);

    // Every device access starts with chip select falling, so this counts accesses.
    always @(negedge cs_n) cs_falls++;

    nvc_host_ctrl #(.TIMER_W(17), .STORE_WAIT(20), .RECALL_WAIT(10)) uut (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .cmd_valid_in(cmd_valid_in),
        .cmd_op_in(cmd_op_in), .cmd_addr_in(cmd_addr_in), .cmd_wdata_in(cmd_wdata_in),
        .cmd_ready_out(cmd_ready), .rsp_valid_out(rsp_valid), .rsp_rdata_out(rdata),
        .chip_sel_n_out(cs_n), .write_n_out(we_n), .out_en_n_out(oe_n),
        .address_bus_out(addr), .data_bus_in(data_wire), .data_bus_out(c_data),
        .data_bus_oe_out(c_oe), .store_busy_pin_n_in(pin_wire),
        .store_busy_pin_n_out(pin_out), .store_busy_pin_n_oe_out(pin_oe));

    nvc_sram_model #(.STORE_NS(1900), .RECALL_NS(800)) dev (
        .chip_sel_n_in(cs_n), .write_n_in(we_n), .out_en_n_in(oe_n),
        .address_bus_in(addr), .data_bus_in(data_wire), .data_bus_out(d_data),
        .data_bus_oe_out(d_oe), .store_busy_pin_n_in(pin_wire),
        .store_busy_pull_out(d_pull), .store_count_out(stores),
        .recall_count_out(recalls));

    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    // One command: raise it on an edge and hold it to the edge that sees ready high.
    // Outputs are read right at the edge, before it updates them, so a one-cycle
    // answer pulse is never missed.
    task automatic do_cmd(input nvc_op_type op, input logic [12:0] a, input logic [7:0] w);
        int n;
        n = 0;
        @(posedge clk_in);
        cmd_valid_in <= 1'b1;
        cmd_op_in <= op;
        cmd_addr_in <= a;
        cmd_wdata_in <= w;
        do
        begin
            @(posedge clk_in);
            n++;
        end
        while (cmd_ready !== 1'b1 && n < 3000);
        cmd_valid_in <= 1'b0;
        do
        begin
            @(posedge clk_in);
            n++;
        end
        while (rsp_valid !== 1'b1 && n < 3000);
        rd = rdata;
        if (n >= 3000)
        begin
            fail_count++;
            close_out();
        end
    endtask

    task automatic t_power_up();
        do_cmd(NVC_OP_READ, 13'h0010, 8'h00);
        check(recalls, 8'h01);
        check(rd, 8'hD3);
        $display("power-up recall test done");
    endtask

    task automatic t_rw();
        do_cmd(NVC_OP_WRITE, 13'h0123, 8'h5A);
        do_cmd(NVC_OP_WRITE, 13'h0124, 8'hA5);
        do_cmd(NVC_OP_READ, 13'h0123, 8'h00);
        check(rd, 8'h5A);
        do_cmd(NVC_OP_READ, 13'h0124, 8'h00);
        check(rd, 8'hA5);
        $display("read write test done");
    endtask

    task automatic t_sw();
        int falls0;
        do_cmd(NVC_OP_WRITE, 13'h0200, 8'h3C);
        falls0 = cs_falls;
        do_cmd(NVC_OP_SW_STORE, 13'h0000, 8'h00);
        check(stores, 8'h01);
        check(8'(cs_falls - falls0), 8'h06);
        do_cmd(NVC_OP_WRITE, 13'h0200, 8'hC3);
        falls0 = cs_falls;
        do_cmd(NVC_OP_SW_RECALL, 13'h0000, 8'h00);
        check(recalls, 8'h02);
        check(8'(cs_falls - falls0), 8'h06);
        check(stores, 8'h01);
        do_cmd(NVC_OP_READ, 13'h0200, 8'h00);
        check(rd, 8'h3C);
        $display("software store recall test done");
    endtask

    task automatic t_hw();
        int falls0;
        do_cmd(NVC_OP_WRITE, 13'h0300, 8'h77);
        do_cmd(NVC_OP_HW_STORE, 13'h0000, 8'h00);
        check(stores, 8'h02);
        do_cmd(NVC_OP_HW_STORE, 13'h0000, 8'h00);
        check(stores, 8'h02);
        do_cmd(NVC_OP_WRITE, 13'h0300, 8'h00);
        do_cmd(NVC_OP_SW_RECALL, 13'h0000, 8'h00);
        do_cmd(NVC_OP_READ, 13'h0300, 8'h00);
        check(rd, 8'h77);
        // An unknown operation is answered without touching the device.
        falls0 = cs_falls;
        do_cmd(nvc_op_type'(3'h5), 13'h0300, 8'h00);
        check(rd, 8'h77);
        check(8'(cs_falls - falls0), 8'h00);
        $display("pin store test done");
    endtask

    // Reset for five cycles, then run each scenario in turn.
    initial
    begin
        repeat (5) @(posedge clk_in);
        rst_n_in <= 1'b1;
        t_power_up();
        t_rw();
        t_sw();
        t_hw();
        close_out();
    end
endmodule // nvsram_store_recall_control_bench
